//--- logic/uawb_top.v
// Purpose: Async serial port: nine-bit address detect, wake on edge,
//          twelve-bit break transmit, AXI4-Lite registers.
// Assumes: Inputs synchronous to clk; sleep stops clock enable.
// Notes:   Tick is sixteen times the bit rate.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "uawb_map.vh"
module uawb_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // AXI4-Lite write
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Serial lines
    input  wire        serial_receive_line,
    output reg         serial_transmit_line,
    // Interrupt and wake
    output wire        receive_irq,
    output wire        wake_request
);
    // ****************************************
    // Registers
    // ****************************************
    reg  [7:0]  rxctl_q;
    reg  [7:0]  txctl_q;
    reg  [7:0]  baud_q;
    reg  [7:0]  divh_q;
    reg  [7:0]  divl_q;
    reg  [1:0]  irqen_q;
    reg  [7:0]  rxdata_q;
    reg         rxif_q;
    reg         txif_q;
    reg  [7:0]  txbuf_q;
    reg         txfull_q;
    reg         framing_error_flag_q;
    reg         overrun_error_flag_q;
    reg         rx9_q;
    reg         wake_ev_q;
    reg  [15:0] brg_q;
    reg         tick_q;
    reg         rx_prev_q;
    reg  [31:0] awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         aw_q;
    reg         w_q;

    function [3:0] reg_index;
        input [31:0] a;
        begin
            reg_index = a[5:2];
        end
    endfunction

    function mapped;
        input [31:0] a;
        begin
            mapped = (a[31:5] == 27'h0000000);
        end
    endfunction

    // ****************************************
    // AXI4-Lite write
    // ****************************************
    assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
    wire aw_now = aw_q | (s_axi_awvalid & s_axi_awready);
    wire w_now  = w_q | (s_axi_wvalid & s_axi_wready);
    wire [31:0] wa = aw_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_q ? wdata_q : s_axi_wdata;
    wire        wb = w_q ? wstrb_q[0] : s_axi_wstrb[0];
    wire do_wr  = ce & aw_now & w_now & ~s_axi_bvalid;
    wire wr_ok  = do_wr & mapped(wa) & wb;
    wire [3:0] wi = reg_index(wa);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awaddr_q     <= 32'h00000000;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UAWB_RESP_OKAY;
        end else if (ce) begin
            if (do_wr) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wa) ? `UAWB_RESP_OKAY
                                           : `UAWB_RESP_SLV;
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    aw_q     <= 1'b1;
                    awaddr_q <= s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    w_q     <= 1'b1;
                    wdata_q <= s_axi_wdata;
                    wstrb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid & s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Baud tick, sixteen per bit
    // ****************************************
    wire port_on = rxctl_q[`UAWB_RC_PEN] & ~txctl_q[`UAWB_TX_SYNC];
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            brg_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else if (ce) begin
            if (brg_q == 16'h0000) begin
                brg_q  <= {divh_q, divl_q};
                tick_q <= port_on;
            end else begin
                brg_q  <= brg_q - 16'h0001;
                tick_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    reg  [3:0] rx_ovs_q;
    reg  [3:0] rx_bit_q;
    reg  [8:0] rx_sh_q;
    reg        rx_busy_q;
    wire       wake_on = baud_q[`UAWB_BC_WAKE];
    wire [3:0] rx_last = rxctl_q[`UAWB_RC_NINE] ? `UAWB_NIN_BITS
                                                : `UAWB_DAT_BITS;
    wire rx_fall = rx_prev_q & ~serial_receive_line;
    wire rx_rise = ~rx_prev_q & serial_receive_line;
    wire rd_data;
    wire rx_done = tick_q & rx_busy_q & (rx_ovs_q == `UAWB_OVS_MID)
                   & (rx_bit_q == rx_last + 4'h1);
    wire keep = ~(rxctl_q[`UAWB_RC_ADDR] & rxctl_q[`UAWB_RC_NINE]
                  & ~rx_sh_q[8]);
    wire continuous_receive_enable = rxctl_q[`UAWB_RC_CONTINUOUS_RECEIVE_ENABLE];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_prev_q <= 1'b1;
            rx_ovs_q  <= 4'h0;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 9'h000;
            rx_busy_q <= 1'b0;
            rxdata_q  <= 8'h00;
            rx9_q     <= 1'b0;
            framing_error_flag_q    <= 1'b0;
            overrun_error_flag_q    <= 1'b0;
            rxif_q    <= 1'b0;
            wake_ev_q <= 1'b0;
        end else if (ce) begin
            rx_prev_q <= serial_receive_line;
            if (wake_on | ~continuous_receive_enable | ~port_on) begin
                rx_busy_q <= 1'b0;
            end else if (tick_q) begin
                rx_ovs_q <= rx_ovs_q + 4'h1;
                if (~rx_busy_q) begin
                    if (~serial_receive_line) begin
                        rx_busy_q <= 1'b1;
                        rx_ovs_q  <= 4'h0;
                        rx_bit_q  <= 4'h0;
                    end
                end else if (rx_ovs_q == `UAWB_OVS_MID) begin
                    rx_bit_q <= rx_bit_q + 4'h1;
                    if (rx_bit_q == 4'h0 && serial_receive_line)
                        rx_busy_q <= 1'b0;
                    else if (rx_bit_q != 4'h0 && rx_bit_q <= rx_last)
                        rx_sh_q <= rxctl_q[`UAWB_RC_NINE] ?
                            {serial_receive_line, rx_sh_q[8:1]} :
                            {1'b0, serial_receive_line, rx_sh_q[7:1]};
                end
            end
            if (rx_done) begin
                rx_busy_q <= 1'b0;
                if (keep) begin
                    if (rxif_q & ~rd_data) begin
                        overrun_error_flag_q <= 1'b1;
                    end else begin
                        rxdata_q <= rx_sh_q[7:0];
                        rx9_q    <= rx_sh_q[8];
                        framing_error_flag_q   <= ~serial_receive_line;
                    end
                end
            end
            if (~continuous_receive_enable) begin
                framing_error_flag_q <= 1'b0;
                overrun_error_flag_q <= 1'b0;
            end
            if (wake_on & rx_fall & port_on)
                wake_ev_q <= 1'b1;
            else if (rd_data)
                wake_ev_q <= 1'b0;
            if ((rx_done & keep & ~(rxif_q & ~rd_data))
                | (wake_on & rx_fall & port_on))
                rxif_q <= 1'b1;
            else if (rd_data)
                rxif_q <= 1'b0;
        end
    end
    assign receive_irq  = rxif_q & irqen_q[`UAWB_IR_RXIE]
                          & irqen_q[`UAWB_IR_GIE];
    // Wake level is combinational so a stopped clock still reports it
    assign wake_request = wake_on & port_on & ~serial_receive_line;

    // ****************************************
    // Transmitter
    // ****************************************
    reg  [3:0] tx_ovs_q;
    reg  [3:0] tx_bit_q;
    reg  [7:0] tx_sh_q;
    reg        tx_busy_q;
    reg        tx_brk_q;
    wire [3:0] tx_n = tx_brk_q ? `UAWB_BRK_BITS : `UAWB_DAT_BITS;
    wire tx_load = ~tx_busy_q & txfull_q & txctl_q[`UAWB_TX_EN] & port_on;
    wire tx_end  = tx_busy_q & tick_q & (tx_ovs_q == `UAWB_OVS_LAST)
                   & (tx_bit_q == tx_n + 4'h1);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_ovs_q  <= 4'h0;
            tx_bit_q  <= 4'h0;
            tx_sh_q   <= 8'h00;
            tx_busy_q <= 1'b0;
            tx_brk_q  <= 1'b0;
            serial_transmit_line <= 1'b1;
        end else if (ce) begin
            if (tx_load) begin
                tx_busy_q <= 1'b1;
                tx_brk_q  <= txctl_q[`UAWB_TX_BRK];
                tx_sh_q   <= txctl_q[`UAWB_TX_BRK] ? 8'h00 : txbuf_q;
                tx_ovs_q  <= 4'h0;
                tx_bit_q  <= 4'h0;
                serial_transmit_line <= 1'b0;
            end else if (tx_end) begin
                tx_busy_q <= 1'b0;
                tx_brk_q  <= 1'b0;
            end else if (tx_busy_q & tick_q) begin
                tx_ovs_q <= tx_ovs_q + 4'h1;
                if (tx_ovs_q == `UAWB_OVS_LAST) begin
                    tx_bit_q <= tx_bit_q + 4'h1;
                    if (tx_bit_q < tx_n) begin
                        serial_transmit_line <= tx_sh_q[0];
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                    end else begin
                        serial_transmit_line <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rxctl_q  <= 8'h00;
            txctl_q  <= `UAWB_RST_TXCTL;
            baud_q   <= `UAWB_RST_BAUD;
            divh_q   <= 8'h00;
            divl_q   <= 8'h00;
            irqen_q  <= 2'b00;
            txbuf_q  <= 8'h00;
            txfull_q <= 1'b0;
            txif_q   <= 1'b0;
        end else if (ce) begin
            if (wr_ok && wi == `UAWB_OFF_RXCTL)
                rxctl_q <= {wd[7:3], 3'b000};
            if (wr_ok && wi == `UAWB_OFF_TXCTL)
                txctl_q <= {1'b0, wd[6:2], 2'b00};
            if (tx_end & tx_brk_q)
                txctl_q[`UAWB_TX_BRK] <= 1'b0;
            txctl_q[`UAWB_TX_EMPTY] <= ~(tx_busy_q | tx_load) | tx_end;
            if (wr_ok && wi == `UAWB_OFF_BAUD)
                baud_q[`UAWB_BC_WAKE] <= wd[`UAWB_BC_WAKE];
            if (baud_q[`UAWB_BC_WAKE] & wake_ev_q & rx_rise)
                baud_q[`UAWB_BC_WAKE] <= 1'b0;
            baud_q[`UAWB_BC_IDLE] <= ~rx_busy_q;
            if (wr_ok && wi == `UAWB_OFF_DIVH)
                divh_q <= wd[7:0];
            if (wr_ok && wi == `UAWB_OFF_DIVL)
                divl_q <= wd[7:0];
            if (wr_ok && wi == `UAWB_OFF_IRQ)
                irqen_q <= wd[1:0];
            // Load wins over hand-off so a fresh byte is never lost
            if (wr_ok && wi == `UAWB_OFF_TXBUF) begin
                txbuf_q  <= wd[7:0];
                txfull_q <= 1'b1;
            end else if (tx_load) begin
                txfull_q <= 1'b0;
            end
            txif_q <= txctl_q[`UAWB_TX_EN] & ~(wr_ok && wi ==
                      `UAWB_OFF_TXBUF) & (~txfull_q | tx_load);
        end
    end

    // ****************************************
    // AXI4-Lite read
    // ****************************************
    assign s_axi_arready = ~s_axi_rvalid;
    wire do_rd = ce & s_axi_arvalid & s_axi_arready;
    assign rd_data = do_rd & mapped(s_axi_araddr)
                     & (reg_index(s_axi_araddr) == `UAWB_OFF_RXDATA);
    reg [7:0] rmux;
    always @* begin
        case (reg_index(s_axi_araddr))
            `UAWB_OFF_RXCTL:  rmux = {rxctl_q[7:3], framing_error_flag_q, overrun_error_flag_q,
                                      rx9_q};
            `UAWB_OFF_RXDATA: rmux = rxdata_q;
            `UAWB_OFF_TXCTL:  rmux = txctl_q;
            `UAWB_OFF_BAUD:   rmux = baud_q;
            `UAWB_OFF_DIVH:   rmux = divh_q;
            `UAWB_OFF_DIVL:   rmux = divl_q;
            `UAWB_OFF_IRQ:    rmux = {4'h0, txif_q, rxif_q, irqen_q};
            default:          rmux = 8'h00;
        endcase
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `UAWB_RESP_OKAY;
        end else if (ce) begin
            if (do_rd) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000,
                                 mapped(s_axi_araddr) ? rmux : 8'h00};
                s_axi_rresp  <= mapped(s_axi_araddr) ? `UAWB_RESP_OKAY
                                                     : `UAWB_RESP_SLV;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // uawb_top
`default_nettype wire

//--- logic/uawb_map.vh
// Purpose: Register map and constants for the serial port with address
//          detect, wake-on-edge and break transmit.
// Assumes: AXI4-Lite, one aligned 32-bit word per 8-bit register.
// Notes:   Behaviour list below.
//
// Behaviour
// - Address detect cleared: every frame buffered, flagged
// - Receive flag set; interrupt needs both enables
// - Status shows framing, overrun, received ninth bit
// - Clearing continuous receive clears latched errors
// - Sleep stops clocks; no normal reception
// - Wake enable at baud control bit one
// - Wake enabled: reception suspended, watch line
// - Falling receive edge is wake event
// - Wake event sets receive interrupt flag
// - Reading receive data clears wake condition
// - First rising edge clears wake enable
// - Break: start, twelve zeros, stop
// - Send break and transmit enable at load
// - Send break cleared after stop; next byte normal
// - Shifter empty flag tracks break too
// - Data bits least significant first
// - Receive sampled at sixteen times baud
// - Buffer hand-off sets transmit flag, not clearable
`ifndef UAWB_MAP_VH
`define UAWB_MAP_VH
// ****************************************
// Register word indices (byte offset divided by four)
// ****************************************
`define UAWB_OFF_RXCTL   4'h0
`define UAWB_OFF_RXDATA  4'h1
`define UAWB_OFF_TXCTL   4'h2
`define UAWB_OFF_TXBUF   4'h3
`define UAWB_OFF_BAUD    4'h4
`define UAWB_OFF_DIVH    4'h5
`define UAWB_OFF_DIVL    4'h6
`define UAWB_OFF_IRQ     4'h7
// ****************************************
// Field positions
// ****************************************
`define UAWB_RC_PEN      7
`define UAWB_RC_NINE     6
`define UAWB_RC_CONTINUOUS_RECEIVE_ENABLE     4
`define UAWB_RC_ADDR     3
`define UAWB_RC_FRAMING_ERROR_FLAG     2
`define UAWB_RC_OVERRUN_ERROR_FLAG     1
`define UAWB_RC_RX9      0
`define UAWB_TX_EN       5
`define UAWB_TX_SYNC     4
`define UAWB_TX_BRK      3
`define UAWB_TX_EMPTY    1
`define UAWB_BC_IDLE     6
`define UAWB_BC_WAKE     1
`define UAWB_IR_RXIE     0
`define UAWB_IR_GIE      1
`define UAWB_IR_RXIF     2
`define UAWB_IR_TXIF     3
// ****************************************
// Reset values and counts
// ****************************************
`define UAWB_RST_TXCTL   8'h02
`define UAWB_RST_BAUD    8'h40
`define UAWB_OVS_LAST    4'hF
`define UAWB_OVS_MID     4'h7
`define UAWB_BRK_BITS    4'hC
`define UAWB_DAT_BITS    4'h8
`define UAWB_NIN_BITS    4'h9
`define UAWB_RESP_OKAY   2'b00
`define UAWB_RESP_SLV    2'b10
`endif

//--- tb/uawb_props.sv
// Purpose: Port checks for the serial port block.
// Assumes: One clock domain, reset active high.
// Notes:   Bound to uawb_top below.
`timescale 1ns/1ps
`default_nettype none
module uawb_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Serial lines and wake
    input wire logic        serial_receive_line,
    input wire logic        serial_transmit_line,
    input wire logic        wake_request
);
    // ****************************************
    // Low run counter
    // ****************************************
    // Counts only running cycles, so sleep does not skew it
    logic [11:0] low_run_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_run_q <= 12'h000;
        else if (serial_transmit_line)
            low_run_q <= 12'h000;
        else if (ce)
            low_run_q <= low_run_q + 12'h001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_tx_bit_grid: assert property (
        $rose(serial_transmit_line) |-> low_run_q[3:0] == 4'h0)
        else $error("transmit low run not whole bits");
    a_wake_line_low: assert property (
        wake_request |-> !serial_receive_line)
        else $error("wake request with line high");
    a_bvalid_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rvalid_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped or changed");
    a_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while response pending");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce
        |=> s_axi_bvalid)
        else $error("write response late");
    a_read_unmapped: assert property (
        s_axi_arvalid && s_axi_arready && ce && s_axi_araddr >= 32'h20
        |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read answer wrong");
    a_read_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule // uawb_props
bind uawb_top uawb_props uawb_props_i (
    .clk, .rst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_receive_line,
    .serial_transmit_line, .wake_request);
`default_nettype wire

//--- tb/uawb_node.sv
// Purpose: Remote serial node on the receive and transmit lines.
// Assumes: Bit time of BIT_CLKS clocks, idle high line.
// Notes:   Tasks are called just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module uawb_node #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk,
    input  wire logic serial_transmit_line,
    output var  logic serial_receive_line
);
    initial serial_receive_line = 1'b1;
    // Start, n bits least significant first, stop
    task automatic send(input logic [8:0] d, input int n);
        serial_receive_line <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            serial_receive_line <= d[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        serial_receive_line <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk);
    endtask
    // Sample n bits after start at mid-bit; stop included
    task automatic grab(input int n, output logic [12:0] bits);
        int k;
        bits = 13'h0000;
        for (k = 0; k < 4000 && serial_transmit_line !== 1'b0; k++)
            @(posedge clk);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            bits[i] = serial_transmit_line;
        end
    endtask
endmodule // uawb_node
`default_nettype wire

//--- tb/uawb_top_tb_top.sv
// Purpose: Self-checking bench for the serial port block.
// Assumes: Divisor 0, so one tick per clock and 16 clocks a bit.
// Notes:   Register bus is driven by the wr and rd tasks.
`timescale 1ns/1ps
`default_nettype none
`include "uawb_map.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module uawb_top_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic        s_axi_awvalid = 1'b0;
    wire         s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    wire         s_axi_wready;
    wire  [1:0]  s_axi_bresp;
    wire         s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic        s_axi_arvalid = 1'b0;
    wire         s_axi_arready;
    wire  [31:0] s_axi_rdata;
    wire  [1:0]  s_axi_rresp;
    wire         s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    wire         serial_receive_line;
    wire         serial_transmit_line;
    wire         receive_irq;
    wire         wake_request;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    logic [31:0] v;
    logic [1:0]  r;
    logic [12:0] b;
    uawb_top uawb_top_i (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_receive_line,
        .serial_transmit_line, .receive_irq, .wake_request);
    uawb_node uawb_node_i (.clk, .serial_transmit_line,
        .serial_receive_line);
    always #4 clk = ~clk;
    // ****************************************
    // Bus tasks
    // ****************************************
    // Leading edge keeps two tasks from driving one signal in one step
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        int k;
        @(posedge clk);
        s_axi_awaddr <= {26'h0, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (k == 50) timeout();
    endtask
    task automatic rd(input logic [3:0] idx);
        int k;
        @(posedge clk);
        s_axi_araddr <= {26'h0, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (k == 50) timeout();
    endtask
    task automatic wait_irq();
        int k;
        for (k = 0; k < 400 && receive_irq !== 1'b1; k++) @(posedge clk);
        if (k == 400) timeout();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd(`UAWB_OFF_TXCTL);
        `CHK("tx ctl reset", `UAWB_RST_TXCTL, v[7:0])
        rd(`UAWB_OFF_BAUD);
        `CHK("baud reset", `UAWB_RST_BAUD, v[7:0])
        rd(4'h8);
        `CHK("unmapped resp", `UAWB_RESP_SLV, r)
        wr(`UAWB_OFF_DIVH, 8'h00);
        wr(`UAWB_OFF_DIVL, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_addr();
        wr(`UAWB_OFF_IRQ, 8'h03);
        wr(`UAWB_OFF_RXCTL, 8'hD8);
        uawb_node_i.send(9'h012, 9);
        repeat (16) @(posedge clk);
        rd(`UAWB_OFF_IRQ);
        `CHK("dropped frame flag", 1'b0, v[`UAWB_IR_RXIF])
        uawb_node_i.send(9'h1A5, 9);
        wait_irq();
        `CHK("irq line", 1'b1, receive_irq)
        rd(`UAWB_OFF_RXCTL);
        `CHK("ninth bit", 1'b1, v[`UAWB_RC_RX9])
        rd(`UAWB_OFF_RXDATA);
        `CHK("address byte", 8'hA5, v[7:0])
        wr(`UAWB_OFF_RXCTL, 8'hD0);
        uawb_node_i.send(9'h03C, 9);
        wait_irq();
        rd(`UAWB_OFF_RXDATA);
        `CHK("data byte", 8'h3C, v[7:0])
        repeat (2) @(posedge clk);
        `CHK("irq after read", 1'b0, receive_irq)
        $display("test address done");
    endtask
    task automatic t_overrun();
        wr(`UAWB_OFF_IRQ, 8'h01);
        uawb_node_i.send(9'h011, 9);
        uawb_node_i.send(9'h022, 9);
        repeat (16) @(posedge clk);
        `CHK("irq without global", 1'b0, receive_irq)
        rd(`UAWB_OFF_RXCTL);
        `CHK("overrun", 1'b1, v[`UAWB_RC_OVERRUN_ERROR_FLAG])
        wr(`UAWB_OFF_RXCTL, 8'hC0);
        rd(`UAWB_OFF_RXCTL);
        `CHK("overrun cleared", 1'b0, v[`UAWB_RC_OVERRUN_ERROR_FLAG])
        rd(`UAWB_OFF_RXDATA);
        `CHK("first frame kept", 8'h11, v[7:0])
        $display("test overrun done");
    endtask
    task automatic t_wake();
        wr(`UAWB_OFF_RXCTL, 8'h90);
        wr(`UAWB_OFF_IRQ, 8'h03);
        rd(`UAWB_OFF_BAUD);
        `CHK("idle before arm", 1'b1, v[`UAWB_BC_IDLE])
        wr(`UAWB_OFF_BAUD, 8'h02);
        rd(`UAWB_OFF_BAUD);
        `CHK("wake armed", 1'b1, v[`UAWB_BC_WAKE])
        @(posedge clk);
        ce <= 1'b0;
        fork
            uawb_node_i.send(9'h000, 12);
            begin
                repeat (4) @(posedge clk);
                `CHK("wake asleep", 1'b1, wake_request)
                ce <= 1'b1;
            end
        join
        wait_irq();
        `CHK("wake flag", 1'b1, receive_irq)
        rd(`UAWB_OFF_BAUD);
        `CHK("wake cleared", 1'b0, v[`UAWB_BC_WAKE])
        rd(`UAWB_OFF_RXCTL);
        `CHK("no framing", 1'b0, v[`UAWB_RC_FRAMING_ERROR_FLAG])
        rd(`UAWB_OFF_RXDATA);
        repeat (2) @(posedge clk);
        `CHK("wake irq cleared", 1'b0, receive_irq)
        $display("test wake done");
    endtask
    task automatic t_break();
        wr(`UAWB_OFF_TXCTL, 8'h28);
        fork
            uawb_node_i.grab(13, b);
            begin
                wr(`UAWB_OFF_TXBUF, 8'hFF);
                wr(`UAWB_OFF_TXBUF, 8'h55);
                rd(`UAWB_OFF_TXCTL);
                `CHK("shifter busy", 1'b0, v[`UAWB_TX_EMPTY])
            end
        join
        `CHK("break bits", 13'h1000, b)
        uawb_node_i.grab(9, b);
        `CHK("sync byte", 13'h0155, b)
        repeat (32) @(posedge clk);
        rd(`UAWB_OFF_TXCTL);
        `CHK("break bit cleared", 1'b0, v[`UAWB_TX_BRK])
        `CHK("shifter empty", 1'b1, v[`UAWB_TX_EMPTY])
        rd(`UAWB_OFF_IRQ);
        `CHK("tx flag", 1'b1, v[`UAWB_IR_TXIF])
        $display("test break done");
    endtask
    task automatic timeout();
        n_mismatch++;
        report_and_stop();
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_addr();
        t_overrun();
        t_wake();
        t_break();
        report_and_stop();
    end
endmodule // uawb_top_tb_top
`default_nettype wire
